// >>> src/pin_change_interrupt_unit.sv
// pin change detect unit: register file, flags, interrupt and wake
// assumes a one-cycle register strobe port and pins already at logic level
`default_nettype none
module pin_change_interrupt_unit
  import pcd_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [5:0]  i_porta_pin,
  input  wire logic [3:0]  i_portb_pin,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_sleep,
  output var  logic [7:0]  o_rdata,
  output var  logic        o_irq,
  output var  logic        o_summary_flag,
  output var  logic        o_wake
);

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0]      porta_rise_enable;
  logic [7:0]      porta_fall_enable;
  logic [7:0]      portb_rise_enable;
  logic [7:0]      portb_fall_enable;
  logic            change_int_master_enable;
  logic [7:0]      porta_change_flags;
  logic [7:0]      portb_change_flags;
  logic            next_summary;
  logic [7:0]      next_rdata;
  logic [7:0]      ctrl_view;
  logic            wr_porta_flags;
  logic            wr_portb_flags;
  logic            wake_request;
  power_state_type pstate;
  power_state_type next_pstate;

  pcd_edge_if edges ();

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic hit_wr(input logic [3:0] off);
    hit_wr = i_wr && (i_addr == off);
  endfunction

  assign wr_porta_flags = hit_wr(OFF_PORTA_FLAGS);
  assign wr_portb_flags = hit_wr(OFF_PORTB_FLAGS);

  // ****************************************
  // pin sampling and edge detection
  // ****************************************
  pcd_edge_detect u_detect (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_porta_pin (i_porta_pin),
    .i_portb_pin (i_portb_pin),
    .ev          (edges.source)
  );

  // ****************************************
  // edge enable registers
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      porta_rise_enable <= REG_RESET;
    end else if (hit_wr(OFF_PORTA_RISE)) begin
      porta_rise_enable <= i_wdata & PORTA_IMPL_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      porta_fall_enable <= REG_RESET;
    end else if (hit_wr(OFF_PORTA_FALL)) begin
      porta_fall_enable <= i_wdata & PORTA_IMPL_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      portb_rise_enable <= REG_RESET;
    end else if (hit_wr(OFF_PORTB_RISE)) begin
      portb_rise_enable <= i_wdata & PORTB_IMPL_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      portb_fall_enable <= REG_RESET;
    end else if (hit_wr(OFF_PORTB_FALL)) begin
      portb_fall_enable <= i_wdata & PORTB_IMPL_MASK;
    end
  end

  // ****************************************
  // interrupt control register
  // ****************************************
  // summary bit is derived, writes to it are dropped
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      change_int_master_enable <= 1'b0;
    end else if (hit_wr(OFF_INT_CTRL)) begin
      change_int_master_enable <= i_wdata[CTRL_MASTER_EN];
    end
  end

  // ****************************************
  // change flags
  // ****************************************
  // banks run regardless of master enable
  pcd_flag_bank #(
    .IS_PORTB (1'b0)
  ) u_porta_flags (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .ev        (edges.sink),
    .i_rise_en (porta_rise_enable),
    .i_fall_en (porta_fall_enable),
    .i_wr      (wr_porta_flags),
    .i_wdata   (i_wdata),
    .o_flags   (porta_change_flags)
  );

  pcd_flag_bank #(
    .IS_PORTB (1'b1)
  ) u_portb_flags (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .ev        (edges.sink),
    .i_rise_en (portb_rise_enable),
    .i_fall_en (portb_fall_enable),
    .i_wr      (wr_portb_flags),
    .i_wdata   (i_wdata),
    .o_flags   (portb_change_flags)
  );

  // ****************************************
  // summary flag and interrupt request
  // ****************************************
  // one cycle behind the flags so both outputs come from flops
  assign next_summary = (|porta_change_flags) | (|portb_change_flags);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_summary_flag <= 1'b0;
    end else begin
      o_summary_flag <= next_summary;
    end
  end

  // only the request is gated, flags keep collecting
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= next_summary & change_int_master_enable;
    end
  end

  // ****************************************
  // sleep and wake
  // ****************************************
  // wake is taken from the flag register itself, so the flag is
  // always visible before the core can run an instruction
  assign wake_request = change_int_master_enable & next_summary;

  always_comb begin
    next_pstate = pstate;
    unique case (pstate)
      ST_RUN: begin
        if (i_sleep) next_pstate = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!i_sleep) next_pstate = ST_RUN;
        else if (wake_request) next_pstate = ST_WAKE;
      end
      ST_WAKE: begin
        // held until the core drops its sleep level
        if (!i_sleep) next_pstate = ST_RUN;
      end
      default: begin
        next_pstate = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pstate <= ST_RUN;
    end else begin
      pstate <= next_pstate;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= (next_pstate == ST_WAKE);
    end
  end

  // ****************************************
  // register read
  // ****************************************
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[CTRL_MASTER_EN] = change_int_master_enable;
    ctrl_view[CTRL_SUMMARY]   = next_summary;
  end

  always_comb begin
    next_rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        OFF_PORTA_RISE:  next_rdata = porta_rise_enable;
        OFF_PORTA_FALL:  next_rdata = porta_fall_enable;
        OFF_PORTA_FLAGS: next_rdata = porta_change_flags;
        OFF_PORTB_RISE:  next_rdata = portb_rise_enable;
        OFF_PORTB_FALL:  next_rdata = portb_fall_enable;
        OFF_PORTB_FLAGS: next_rdata = portb_change_flags;
        OFF_INT_CTRL:    next_rdata = ctrl_view & CTRL_IMPL_MASK;
        // unmapped addresses answer zero
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// >>> src/pcd_pkg.sv
// constants shared by the pin change detect unit
// assumes a single system clock and a synchronous active-low reset
`default_nettype none
package pcd_pkg;
  // ****************************************
  // register map, byte wide, index = address
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] OFF_PORTA_RISE  = 4'h0;
  localparam logic [3:0] OFF_PORTA_FALL  = 4'h1;
  localparam logic [3:0] OFF_PORTA_FLAGS = 4'h2;
  localparam logic [3:0] OFF_PORTB_RISE  = 4'h3;
  localparam logic [3:0] OFF_PORTB_FALL  = 4'h4;
  localparam logic [3:0] OFF_PORTB_FLAGS = 4'h5;
  localparam logic [3:0] OFF_INT_CTRL    = 4'h6;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam logic [7:0] PORTA_IMPL_MASK = 8'h3F;
  localparam logic [7:0] PORTB_IMPL_MASK = 8'hF0;
  localparam int unsigned PORTA_PINS     = 6;
  localparam int unsigned PORTB_PINS     = 4;
  localparam int unsigned PORTB_LOW_PIN  = 4;
  localparam int unsigned CTRL_MASTER_EN = 0;
  localparam int unsigned CTRL_SUMMARY   = 1;
  localparam logic [7:0] CTRL_IMPL_MASK  = 8'h03;
  localparam logic [7:0] REG_RESET       = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  // sync stages plus the previous-sample stage
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b10
  } power_state_type;

  function automatic logic [7:0] port_mask(input logic is_portb);
    port_mask = is_portb ? PORTB_IMPL_MASK : PORTA_IMPL_MASK;
  endfunction
endpackage
`default_nettype wire

// >>> src/pcd_edge_if.sv
// edge events from the pin detector to the flag banks
// assumes both ends share i_clk
`default_nettype none
interface pcd_edge_if;
  logic [7:0] a_rise;
  logic [7:0] a_fall;
  logic [7:0] b_rise;
  logic [7:0] b_fall;
  modport source (output a_rise, output a_fall,
                  output b_rise, output b_fall);
  modport sink   (input a_rise, input a_fall,
                  input b_rise, input b_fall);
endinterface
`default_nettype wire

// >>> src/pcd_edge_detect.sv
// pin synchronisers and per-pin rise/fall detection
// assumes pins may change at any time relative to i_clk
`default_nettype none
module pcd_edge_detect
  import pcd_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [5:0]  i_porta_pin,
  input  wire logic [3:0]  i_portb_pin,
  pcd_edge_if.source       ev
);
  logic [15:0] pin_vec;
  logic [15:0] meta;
  logic [15:0] cur;
  logic [15:0] prev;
  logic [1:0]  settle;
  logic        armed;

  assign pin_vec = {i_portb_pin, 4'h0, 2'h0, i_porta_pin};
  assign armed   = (settle == SETTLE_CYCLES);

  // no edges until the pipe holds real samples, else reset fakes a rise
  always_ff @(posedge i_clk) begin
    if (!i_nrst) settle <= 2'h0;
    else if (!armed) settle <= settle + 2'h1;
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_pin
      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          meta[g] <= 1'b0;
          cur[g]  <= 1'b0;
          prev[g] <= 1'b0;
        end else begin
          meta[g] <= pin_vec[g];
          cur[g]  <= meta[g];
          prev[g] <= cur[g];
        end
      end
    end
  endgenerate

  assign ev.a_rise = armed ? (cur[7:0] & ~prev[7:0]) : 8'h00;
  assign ev.a_fall = armed ? (~cur[7:0] & prev[7:0]) : 8'h00;
  assign ev.b_rise = armed ? (cur[15:8] & ~prev[15:8]) : 8'h00;
  assign ev.b_fall = armed ? (~cur[15:8] & prev[15:8]) : 8'h00;
endmodule
`default_nettype wire

// >>> src/pcd_flag_bank.sv
// change flags of one port: hardware sets, software writes
// assumes enables and write strobe come from the register file
`default_nettype none
module pcd_flag_bank
  import pcd_pkg::*;
#(
  parameter bit IS_PORTB = 1'b0
)
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  pcd_edge_if.sink         ev,
  input  wire logic [7:0]  i_rise_en,
  input  wire logic [7:0]  i_fall_en,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  output var  logic [7:0]  o_flags
);
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] hit;
  logic [7:0] kept;

  assign rise = IS_PORTB ? ev.b_rise : ev.a_rise;
  assign fall = IS_PORTB ? ev.b_fall : ev.a_fall;
  // either detector may fire, both at once is legal
  assign hit  = (rise & i_rise_en) | (fall & i_fall_en);
  assign kept = i_wr ? i_wdata : o_flags;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) o_flags <= REG_RESET;
    // set beats a same-cycle write of zero
    else o_flags <= (kept | hit) & port_mask(IS_PORTB);
  end
endmodule
`default_nettype wire

// >>> sim/pcd_chk.sv
// port assertions for the pin change detect unit
// assumes it is bound into pin_change_interrupt_unit, one clock
`default_nettype none
module pcd_chk
  import pcd_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic       i_rd,
  input wire logic       i_sleep,
  input wire logic [7:0] o_rdata,
  input wire logic       o_irq,
  input wire logic       o_summary_flag,
  input wire logic       o_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // properties
  // ****
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  chk_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property (
    $past(i_rd) && $past(i_addr) > OFF_INT_CTRL |-> o_rdata == 8'h00)
    else $error("unmapped index read not zero");
  chk_porta_upper: assert property (
    $past(i_rd) && $past(i_addr) <= OFF_PORTA_FLAGS |-> o_rdata[7:6] == 2'h0)
    else $error("port A upper bits not zero");
  chk_portb_lower: assert property (
    $past(i_rd) && $past(i_addr) >= OFF_PORTB_RISE
    && $past(i_addr) <= OFF_PORTB_FLAGS |-> o_rdata[3:0] == 4'h0)
    else $error("port B lower bits not zero");
  chk_irq_summary: assert property (
    o_irq |-> o_summary_flag)
    else $error("request without any flag");
  chk_irq_drop: assert property (
    $fell(o_summary_flag) |-> !o_irq)
    else $error("request outlived the flags");
  chk_wake_irq: assert property (
    $rose(o_wake) |-> o_irq)
    else $error("wake without enabled request");
  chk_wake_release: assert property (
    !i_sleep [*2] |=> !o_wake)
    else $error("wake held outside sleep");
endmodule

bind pin_change_interrupt_unit pcd_chk chk_u (.i_clk, .i_nrst, .i_addr,
  .i_rd, .i_sleep, .o_rdata, .o_irq, .o_summary_flag, .o_wake);
`default_nettype wire

// >>> sim/pcd_pin_model.sv
// far side: port pin levels and the core's interrupt input
// assumes the bench moves pins only through set_pins
`default_nettype none
module pcd_pin_model (
  input  wire logic       i_clk,
  input  wire logic       i_irq,
  output var  logic [5:0] o_porta_pin,
  output var  logic [3:0] o_portb_pin,
  output var  int         o_irq_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // pins and core
  // ****
  initial begin
    o_porta_pin = 6'h00;
    o_portb_pin = 4'h0;
  end
  // core counts each new request, level stays until flags clear
  always @(posedge i_irq) o_irq_count <= o_irq_count + 1;
  // pins held a full cycle or more, narrower pulses may be lost
  task automatic set_pins(input logic [5:0] a, input logic [3:0] b);
    @(posedge i_clk);
    o_porta_pin <= a;
    o_portb_pin <= b;
  endtask
endmodule
`default_nettype wire

// >>> sim/test_pin_change_interrupt_unit.sv
// self-checking bench for the pin change detect unit
// assumes the checker is bound in and pins come from pcd_pin_model
`default_nettype none
module test_pin_change_interrupt_unit
  import pcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk, i_nrst, i_wr, i_rd, i_sleep;
  logic [3:0] i_addr, i_portb_pin;
  logic [7:0] i_wdata, o_rdata, v, w;
  logic [5:0] i_porta_pin;
  logic       o_irq, o_summary_flag, o_wake;
  int         n_errors, n_checks;
  logic [3:0] offs [4] = '{OFF_PORTA_RISE, OFF_PORTA_FALL, OFF_PORTB_RISE,
    OFF_PORTB_FALL};

  pin_change_interrupt_unit dut_u (.i_clk, .i_nrst, .i_porta_pin,
    .i_portb_pin, .i_addr, .i_wdata, .i_wr, .i_rd, .i_sleep, .o_rdata,
    .o_irq, .o_summary_flag, .o_wake);
  pcd_pin_model pins_u (.i_clk, .i_irq(o_irq), .o_porta_pin(i_porta_pin),
    .o_portb_pin(i_portb_pin), .o_irq_count());

  // ****
  // tasks
  // ****
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a,
                        input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask
  // covers two sync stages, the compare and the output register
  task automatic settle;
    repeat (6) @(posedge i_clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****
  // clock, watchdog, tests
  // ****
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    {i_nrst, i_wr, i_rd, i_sleep, i_addr, i_wdata} = '0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int k = 0; k < 8; k++) rd_chk("reset value", 4'(k), 8'h00);
    wr(4'h7, 8'hFF);
    rd_chk("unmapped", 4'h7, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      wr(offs[k], 8'hFF);
      rd_chk("enable", offs[k], port_bits(k));
      wr(offs[k], 8'h00);
    end
    $display("test enables done");
    wr(OFF_PORTA_RISE, 8'h3F);
    pins_u.set_pins(6'h2A, 4'h0);
    settle();
    check("summary", {7'h0, o_summary_flag}, 8'h01);
    check("irq masked", {7'h0, o_irq}, 8'h00);
    pins_u.set_pins(6'h00, 4'h0);
    settle();
    rd(OFF_PORTA_FLAGS, v);
    check("A rise flags", v, 8'h2A);
    // a late edge between the two reads must survive the masked and
    pins_u.set_pins(6'h01, 4'h0);
    settle();
    rd(OFF_PORTA_FLAGS, w);
    wr(OFF_PORTA_FLAGS, (8'hFF ^ v) & w);
    rd_chk("A late edge kept", OFF_PORTA_FLAGS, 8'h01);
    wr(OFF_PORTA_FLAGS, 8'h00);
    rd_chk("A cleared", OFF_PORTA_FLAGS, 8'h00);
    settle();
    check("summary off", {7'h0, o_summary_flag}, 8'h00);
    $display("test port A done");
    wr(OFF_PORTB_FALL, 8'hF0);
    pins_u.set_pins(6'h00, 4'hF);
    settle();
    rd_chk("B rise off", OFF_PORTB_FLAGS, 8'h00);
    pins_u.set_pins(6'h00, 4'h5);
    settle();
    rd_chk("B fall flags", OFF_PORTB_FLAGS, 8'hA0);
    wr(OFF_PORTB_FLAGS, 8'h00);
    rd_chk("B cleared", OFF_PORTB_FLAGS, 8'h00);
    $display("test port B done");
    wr(OFF_PORTA_RISE, 8'h01);
    wr(OFF_PORTA_FALL, 8'h01);
    pins_u.set_pins(6'h01, 4'h5);
    settle();
    rd_chk("both rise", OFF_PORTA_FLAGS, 8'h01);
    wr(OFF_PORTA_FLAGS, 8'h00);
    pins_u.set_pins(6'h00, 4'h5);
    settle();
    rd_chk("both edges", OFF_PORTA_FLAGS, 8'h01);
    wr(OFF_PORTA_FLAGS, 8'h00);
    $display("test both edges done");
    wr(OFF_INT_CTRL, 8'h01);
    i_sleep <= 1'b1;
    pins_u.set_pins(6'h01, 4'h5);
    settle();
    check("wake", {7'h0, o_wake}, 8'h01);
    check("irq", {7'h0, o_irq}, 8'h01);
    check("irq count", 8'(pins_u.o_irq_count), 8'h01);
    rd_chk("flags at wake", OFF_PORTA_FLAGS, 8'h01);
    rd_chk("control", OFF_INT_CTRL, 8'h03);
    i_sleep <= 1'b0;
    wr(OFF_PORTA_FLAGS, 8'h00);
    settle();
    check("wake off", {7'h0, o_wake}, 8'h00);
    check("irq off", {7'h0, o_irq}, 8'h00);
    $display("test sleep done");
    // write of zero lands on the very edge that sets the flag
    pins_u.set_pins(6'h00, 4'h5);
    @(posedge i_clk);
    wr(OFF_PORTA_FLAGS, 8'h00);
    rd_chk("set beats clear", OFF_PORTA_FLAGS, 8'h01);
    wr(OFF_PORTA_FLAGS, 8'h00);
    $display("test set wins done");
    print_verdict();
  end

  function automatic logic [7:0] port_bits(input int k);
    port_bits = (k < 2) ? PORTA_IMPL_MASK : PORTB_IMPL_MASK;
  endfunction
endmodule
`default_nettype wire
